// File: hw/fwc_pkg.sv
// constants and types for the flash write operation control block
package fwc_pkg;
	localparam logic [19:0] OFS_STATUS_LOW   = 20'h80000;
	localparam logic [19:0] OFS_CONTROL_HIGH = 20'h80002;
	localparam logic [15:0] RST_STATUS_LOW   = 16'h0000;
	localparam logic [15:0] RST_CONTROL_HIGH = 16'h0000;
	// status low fields
	localparam int BIT_BUSY  = 1;
	localparam int BIT_LOCK  = 4;
	// control high fields
	localparam int BIT_START = 15;
	localparam int BIT_HALT  = 14;
	localparam int BIT_WPG   = 13;
	localparam int BIT_DOUBLE_WORD_PROGRAM_SELECT  = 12;
	localparam int BIT_SER   = 11;
	localparam int BIT_SPR   = 8;
	localparam logic [15:0] CTRL_WR_MASK = 16'hf900;
	// protection address window, kept as printed
	localparam logic [23:0] PROT_ADDR_A = 24'h0e8fb0;
	localparam logic [23:0] PROT_ADDR_B = 24'h08dfbf;
	localparam logic [15:0] TRAP_CODE   = 16'h009b;
	localparam int NUM_SECTORS = 8;
	// operation durations
	localparam int T_PROG_NS  = 10000;
	localparam int T_ERASE_NS = 100000;
	localparam int T_PROT_NS  = 10000;
	localparam int CLK_NS     = 25;
	localparam logic [12:0] PROG_CYC  = 13'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [12:0] PROT_CYC  = 13'((T_PROT_NS + CLK_NS - 1) / CLK_NS);
	localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [2:0] {
		FWC_IDLE, FWC_RUN, FWC_PROG_HALT_REQUEST_BIT, FWC_ERASE_HALT_REQUEST_BIT, FWC_PROG_IN_ESUSP
	} fwc_state_t;
	typedef enum logic [1:0] {OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} fwc_op_t;
endpackage

// File: hw/fwc_ctrl.sv
// flash write operation control and status registers
`timescale 1ns/100ps
module fwc_ctrl #(
	parameter int ERASE_CYCLES = fwc_pkg::ERASE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ce,
	// register port, 16-bit
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [19:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_trap,
	// other flash registers content
	input  wire logic [23:0] target_addr,
	input  wire logic [7:0]  sector_select_bits,
	input  wire logic        op_error_in,
	input  wire logic        other_reg_access,
	input  wire logic        bank_access,
	// array side
	output logic             bank_busy_flag,
	output logic             reg_lock,
	output logic             bank_trap,
	output logic             array_wr_ok,
	output logic             array_prog_start,
	output logic             array_erase_start,
	output logic             array_halt,
	output logic             sequence_error_flag,
	output logic             err_update_ok,
	output logic             sector_clear,
	output logic [7:0]       erase_sectors
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		fwc_pkg::fwc_state_t st;
		fwc_pkg::fwc_op_t    op;
		fwc_pkg::fwc_op_t    halt_request_bit_op;
		logic [15:0] ctrl;
		logic        busy;
		logic        lock;
		logic [31:0] cnt;
		logic [31:0] ecnt;
		logic [15:0] rdata;
		logic        trap;
		logic        btrap;
		logic        wr_ok;
		logic        pstart;
		logic        estart;
		logic        halt;
		logic        seqerr;
		logic        err_ok;
		logic        sclr;
		logic [7:0]  esect;
	} fwc_regs_t;

	fwc_regs_t r;
	fwc_regs_t next_r;

	logic        wr_ctrl;
	logic        rd_status;
	logic        rd_ctrl;
	logic        start_req;
	logic [15:0] wval;
	fwc_pkg::fwc_op_t sel_op;
	logic        sel_any;
	logic        prot_bad;

	always_comb begin
		next_r = r;
		rd_status = reg_sel && !reg_wr && reg_addr == fwc_pkg::OFS_STATUS_LOW;
		rd_ctrl = reg_sel && !reg_wr && reg_addr == fwc_pkg::OFS_CONTROL_HIGH;
		wr_ctrl = reg_sel && reg_wr && reg_addr == fwc_pkg::OFS_CONTROL_HIGH && !r.lock;
		wval = reg_wdata & fwc_pkg::CTRL_WR_MASK;
		sel_any = 1'b1;
		sel_op = fwc_pkg::OP_WORD;
		if (wval[fwc_pkg::BIT_SPR]) begin
			sel_op = fwc_pkg::OP_PROT;
		end else if (wval[fwc_pkg::BIT_SER]) begin
			sel_op = fwc_pkg::OP_ERASE;
		end else if (wval[fwc_pkg::BIT_DOUBLE_WORD_PROGRAM_SELECT]) begin
			sel_op = fwc_pkg::OP_DWORD;
		end else if (wval[fwc_pkg::BIT_WPG]) begin
			sel_op = fwc_pkg::OP_WORD;
		end else begin
			sel_any = 1'b0;
		end
		// window bounds taken as the lower and upper of the two printed values
		prot_bad = target_addr < fwc_pkg::PROT_ADDR_B || target_addr > fwc_pkg::PROT_ADDR_A;
		start_req = wr_ctrl && wval[fwc_pkg::BIT_START] && sel_any && !op_error_in;
		next_r.pstart = 1'b0;
		next_r.estart = 1'b0;
		next_r.halt = 1'b0;
		next_r.sclr = 1'b0;
		next_r.trap = 1'b0;
		next_r.rdata = 16'h0000;
		// register read side
		if (rd_status) begin
			next_r.rdata[fwc_pkg::BIT_LOCK] = r.lock;
			if (!r.lock) begin
				next_r.rdata[fwc_pkg::BIT_BUSY] = r.busy;
			end
		end else if (rd_ctrl) begin
			if (r.lock) begin
				next_r.rdata = fwc_pkg::TRAP_CODE;
				next_r.trap = 1'b1;
			end else begin
				next_r.rdata = r.ctrl & fwc_pkg::CTRL_WR_MASK;
			end
		end
		if (other_reg_access && r.lock) begin
			next_r.trap = 1'b1;
		end
		// writes of zero to the start bit are ignored; only the halt bit and the selects follow software
		if (wr_ctrl && r.st == fwc_pkg::FWC_IDLE) begin
			next_r.ctrl[fwc_pkg::BIT_HALT] = wval[fwc_pkg::BIT_HALT];
			next_r.ctrl[13:11] = wval[13:11];
			next_r.ctrl[fwc_pkg::BIT_SPR] = wval[fwc_pkg::BIT_SPR];
		end
		unique case (r.st)
			fwc_pkg::FWC_IDLE: begin
				if (start_req && !wval[fwc_pkg::BIT_HALT]) begin
					next_r.ctrl = wval;
					next_r.op = sel_op;
					next_r.busy = 1'b1;
					next_r.lock = 1'b1;
					next_r.cnt = 32'(fwc_pkg::PROG_CYC);
					if (sel_op == fwc_pkg::OP_ERASE) begin
						next_r.cnt = 32'(ERASE_CYCLES);
						next_r.estart = 1'b1;
						next_r.esect = sector_select_bits;
					end else begin
						next_r.pstart = 1'b1;
					end
					if (sel_op == fwc_pkg::OP_PROT) begin
						next_r.cnt = 32'(fwc_pkg::PROT_CYC);
						next_r.seqerr = prot_bad;
					end else begin
						next_r.seqerr = 1'b0;
					end
					next_r.st = fwc_pkg::FWC_RUN;
				end
			end
			fwc_pkg::FWC_RUN, fwc_pkg::FWC_PROG_IN_ESUSP: begin
				if (reg_sel && reg_wr && reg_addr == fwc_pkg::OFS_CONTROL_HIGH && reg_wdata[fwc_pkg::BIT_HALT]
					&& r.st == fwc_pkg::FWC_RUN && r.op != fwc_pkg::OP_PROT) begin
					// suspend is the one write honoured while locked
					next_r.busy = 1'b0;
					next_r.lock = 1'b0;
					next_r.halt = 1'b1;
					next_r.ctrl[fwc_pkg::BIT_START] = 1'b0;
					next_r.ctrl[fwc_pkg::BIT_HALT] = 1'b1;
					next_r.halt_request_bit_op = r.op;
					next_r.st = r.op == fwc_pkg::OP_ERASE ? fwc_pkg::FWC_ERASE_HALT_REQUEST_BIT : fwc_pkg::FWC_PROG_HALT_REQUEST_BIT;
				end else if (r.cnt <= 32'd1 || r.seqerr) begin
					next_r.busy = 1'b0;
					next_r.lock = 1'b0;
					next_r.ctrl[fwc_pkg::BIT_START] = 1'b0;
					next_r.ctrl[13:11] = 3'b000;
					next_r.ctrl[fwc_pkg::BIT_SPR] = 1'b0;
					next_r.sclr = !op_error_in && !r.seqerr;
					if (!next_r.sclr && r.op == fwc_pkg::OP_ERASE) begin
						next_r.esect = r.esect;
					end else if (r.st == fwc_pkg::FWC_RUN) begin
						next_r.esect = 8'h00;
					end
					if (r.st == fwc_pkg::FWC_PROG_IN_ESUSP) begin
						next_r.cnt = r.ecnt;
					end
					next_r.st = r.st == fwc_pkg::FWC_PROG_IN_ESUSP ? fwc_pkg::FWC_ERASE_HALT_REQUEST_BIT : fwc_pkg::FWC_IDLE;
				end else begin
					next_r.cnt = r.cnt - 32'd1;
				end
			end
			fwc_pkg::FWC_PROG_HALT_REQUEST_BIT, fwc_pkg::FWC_ERASE_HALT_REQUEST_BIT: begin
				if (wr_ctrl) begin
					next_r.ctrl[fwc_pkg::BIT_HALT] = wval[fwc_pkg::BIT_HALT];
				end
				if (start_req && sel_op == r.halt_request_bit_op) begin
					next_r.busy = 1'b1;
					next_r.lock = 1'b1;
					next_r.ctrl = wval & ~(16'h0001 << fwc_pkg::BIT_HALT);
					next_r.op = r.halt_request_bit_op;
					if (r.halt_request_bit_op == fwc_pkg::OP_ERASE) begin
						next_r.estart = 1'b1;
					end else begin
						next_r.pstart = 1'b1;
					end
					next_r.st = fwc_pkg::FWC_RUN;
				end else if (start_req && r.st == fwc_pkg::FWC_ERASE_HALT_REQUEST_BIT
					&& (sel_op == fwc_pkg::OP_WORD || sel_op == fwc_pkg::OP_DWORD)) begin
					next_r.busy = 1'b1;
					next_r.lock = 1'b1;
					next_r.ctrl = wval | (16'h0001 << fwc_pkg::BIT_HALT);
					next_r.op = sel_op;
					next_r.pstart = 1'b1;
					next_r.cnt = 32'(fwc_pkg::PROG_CYC);
					// erase time left, restored when this program ends
					next_r.ecnt = r.cnt;
					next_r.st = fwc_pkg::FWC_PROG_IN_ESUSP;
				end
			end
			default: begin
				next_r.st = fwc_pkg::FWC_IDLE;
			end
		endcase
		next_r.btrap = bank_access && r.busy;
		next_r.wr_ok = !next_r.busy;
		next_r.err_ok = !next_r.lock && !next_r.busy;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.ctrl <= fwc_pkg::RST_CONTROL_HIGH;
			r.wr_ok <= 1'b1;
			r.err_ok <= 1'b1;
		end else if (ce) begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign reg_rdata = r.rdata;
	assign reg_trap = r.trap;
	assign bank_busy_flag = r.busy;
	assign reg_lock = r.lock;
	assign bank_trap = r.btrap;
	assign array_wr_ok = r.wr_ok;
	assign array_prog_start = r.pstart;
	assign array_erase_start = r.estart;
	assign array_halt = r.halt;
	assign sequence_error_flag = r.seqerr;
	assign err_update_ok = r.err_ok;
	assign sector_clear = r.sclr;
	assign erase_sectors = r.esect;
endmodule

// File: verif/fwc_checker.sv
// assertion checker for the flash write control block
`timescale 1ns/100ps
module fwc_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// watched ports
	input wire logic        ce,
	input wire logic        reg_sel,
	input wire logic        reg_wr,
	input wire logic [19:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_trap,
	input wire logic        op_error_in,
	input wire logic        bank_access,
	input wire logic        bank_busy_flag,
	input wire logic        reg_lock,
	input wire logic        bank_trap,
	input wire logic        array_prog_start,
	input wire logic        array_halt,
	input wire logic        err_update_ok,
	input wire logic        sector_clear
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_ctrl_wr;
		ce && reg_sel && reg_wr && reg_addr == 20'h80002;
	endsequence
	sequence s_start;
		s_ctrl_wr and (reg_wdata == 16'ha000 && !reg_lock && !op_error_in);
	endsequence
	start_busy_a: assert property (s_start |=> bank_busy_flag && reg_lock) else $error("start missed");
	lock_trap_a: assert property (ce && reg_sel && !reg_wr && reg_addr == 20'h80002 && reg_lock
		|=> reg_trap && reg_rdata == 16'h009b) else $error("locked read not trapped");
	bank_trap_a: assert property (ce && bank_busy_flag && bank_access |=> bank_trap) else $error("no bank trap");
	err_refuse_a: assert property ((s_ctrl_wr and (op_error_in && !reg_lock && !bank_busy_flag))
		|=> !bank_busy_flag) else $error("start taken with error");
	halt_clear_a: assert property (array_halt |-> !bank_busy_flag && !reg_lock) else $error("halt kept busy");
	err_hold_a: assert property (bank_busy_flag && $past(bank_busy_flag) |-> !err_update_ok) else $error("early err");
	prog_busy_a: assert property (array_prog_start |-> bank_busy_flag) else $error("program without busy");
	clear_pulse_a: assert property (sector_clear |-> !bank_busy_flag ##1 !sector_clear) else $error("bad clear");
endmodule
//////////////////////////////////////////////////////////////////
bind fwc_ctrl fwc_checker u_chk (.clk, .srst, .ce, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_trap,
	.op_error_in, .bank_access, .bank_busy_flag, .reg_lock, .bank_trap, .array_prog_start, .array_halt,
	.err_update_ok, .sector_clear);

// File: verif/tb_top.sv
// self-checking bench for the flash write control block
`timescale 1ns/100ps
module tb_top;
	logic        clk, srst, ce, reg_sel, reg_wr, op_error_in, other_reg_access, bank_access;
	logic [19:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_q;
	logic [23:0] target_addr;
	logic [7:0]  sector_select_bits, erase_sectors;
	logic        reg_trap, bank_busy_flag, reg_lock, bank_trap, array_wr_ok, array_prog_start;
	logic        array_erase_start, array_halt, sequence_error_flag, err_update_ok, sector_clear;
	int          failures, checks;
	fwc_ctrl #(.ERASE_CYCLES(20)) DUT (.clk, .srst, .ce, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_trap, .target_addr, .sector_select_bits, .op_error_in, .other_reg_access, .bank_access,
		.bank_busy_flag, .reg_lock, .bank_trap, .array_wr_ok, .array_prog_start, .array_erase_start,
		.array_halt, .sequence_error_flag, .err_update_ok, .sector_clear, .erase_sectors);
	//////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d);
		reg_sel = 1'b1;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		// select stays up between back-to-back accesses; callers release it
		rd_q = reg_rdata;
	endtask
	task automatic wait_done(input int n);
		reg_sel = 1'b0;
		for (int i = 0; i < n && reg_lock !== 1'b0; i++) @(negedge clk);
		chk("lock", 16'h0, {15'h0, reg_lock});
		if (reg_lock !== 1'b0) end_sim();
		chk("clear", 16'h1, {15'h0, sector_clear});
		chk("err_ok", 16'h1, {15'h0, err_update_ok});
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////
	task automatic t_word;
		acc(1, 20'h80002, 16'ha000);
		chk("busy", 16'h1, {15'h0, bank_busy_flag});
		chk("prog_start", 16'h1, {15'h0, array_prog_start});
		chk("wr_ok", 16'h0, {15'h0, array_wr_ok});
		chk("err_ok", 16'h0, {15'h0, err_update_ok});
		acc(0, 20'h80000, 16'h0);
		chk("status", 16'h0010, rd_q);
		acc(0, 20'h80002, 16'h0);
		chk("trap", 16'h009b, reg_trap ? rd_q : 16'hffff);
		reg_sel = 1'b0;
		bank_access = 1'b1;
		other_reg_access = 1'b1;
		@(negedge clk);
		bank_access = 1'b0;
		other_reg_access = 1'b0;
		chk("bank_trap", 16'h1, {15'h0, bank_trap});
		chk("other_trap", 16'h1, {15'h0, reg_trap});
		wait_done(500);
		acc(0, 20'h80002, 16'h0);
		chk("ctrl", 16'h0, rd_q);
		$display("word done");
	endtask
	task automatic t_halt_request_bit;
		acc(1, 20'h80002, 16'h9000);
		acc(1, 20'h80002, 16'h4000);
		chk("halt", 16'h1, {15'h0, array_halt & ~bank_busy_flag});
		acc(1, 20'h80002, 16'h1000);
		acc(1, 20'h80002, 16'h8800);
		chk("refuse", 16'h0, {15'h0, bank_busy_flag});
		acc(1, 20'h80002, 16'h9000);
		chk("resume", 16'h1, {15'h0, bank_busy_flag});
		wait_done(500);
		sector_select_bits = 8'h05;
		acc(1, 20'h80002, 16'h8800);
		chk("sectors", 16'h0005, {8'h0, erase_sectors});
		chk("erase_start", 16'h1, {15'h0, array_erase_start});
		acc(1, 20'h80002, 16'h4000);
		chk("sect_hold", 16'h0005, {8'h0, erase_sectors});
		acc(1, 20'h80002, 16'h0800);
		acc(1, 20'h80002, 16'ha000);
		chk("prog_in_halt_request_bit", 16'h1, {15'h0, bank_busy_flag});
		wait_done(500);
		acc(1, 20'h80002, 16'h8800);
		chk("erase_resume", 16'h1, {15'h0, bank_busy_flag});
		reg_sel = 1'b0;
		repeat (10) @(negedge clk);
		chk("erase_left", 16'h1, {15'h0, reg_lock});
		wait_done(60);
		$display("suspend done");
	endtask
	task automatic t_err;
		op_error_in = 1'b1;
		acc(1, 20'h80002, 16'ha000);
		chk("err_start", 16'h0, {15'h0, bank_busy_flag});
		op_error_in = 1'b0;
		acc(1, 20'h80002, 16'h2000);
		chk("no_start", 16'h0, {15'h0, bank_busy_flag});
		target_addr = 24'h000000;
		acc(1, 20'h80002, 16'h8100);
		reg_sel = 1'b0;
		repeat (2) @(negedge clk);
		chk("seq_err", 16'h1, {15'h0, sequence_error_flag});
		target_addr = 24'h0a0000;
		acc(1, 20'h80002, 16'h8100);
		chk("prot_busy", 16'h1, {15'h0, bank_busy_flag});
		reg_sel = 1'b0;
		ce = 1'b0;
		repeat (450) @(negedge clk);
		chk("ce_hold", 16'h1, {15'h0, bank_busy_flag});
		ce = 1'b1;
		wait_done(500);
		$display("error done");
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{srst, ce, reg_sel, reg_wr, op_error_in, other_reg_access, bank_access} = 7'h60;
		{reg_addr, reg_wdata, target_addr, sector_select_bits} = '0;
		failures = 0;
		checks = 0;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		acc(0, 20'h80002, 16'h0);
		chk("ctrl_rst", 16'h0000, rd_q);
		chk("wr_ok", 16'h1, {15'h0, array_wr_ok});
		t_word();
		t_halt_request_bit();
		t_err();
		end_sim();
	end
endmodule
